/* hdl/pewp_host.sv */
/*
 * Host sequencer for a byte-wide EEPROM: reads, latched byte writes with
 * completion polling on bit 7, and the optional chip erase.
 * Assumes the memory's pins are joined to pins_o and byte_lines_i by the
 * surrounding board or testbench, which resolves the shared byte lines.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// (R1) Array is 2K or 4K bytes, eight lines
// (R2) Address stable first, then chip enable low
// (R3) Write enable held high throughout reads
// (R4) Memory drives lines only during valid read
// (R5) Read latches transparent, outputs follow inputs
// (R6) Write starts: WE low, CE low, OE high
// (R7) Address captured on later falling strobe
// (R8) Data captured on earlier rising strobe
// (R9) WE low only minimum pulse; device finishes
// (R10) Memory erases byte itself before programming
// (R11) Internal write finishes within 5 ms
// (R12) Busy reads show inverted bit 7
// (R13) Finished reads show true stored byte
// (R14) Poll bit 7 with ordinary reads, any address
// (R15) No write before valid WE falling transition
// (R16) Other control combinations inhibit writing
// (R17) Optional chip erase with elevated OE
// (R18) Strobe shorter than 20 ns is ignored
// (R19) Busy memory ignores strobes, only polling
module pewp_host
#(
    parameter int unsigned PROGRAM_CYCLES = pewp_pkg::PROGRAM_CYC,
    parameter int unsigned ERASE_CYCLES = pewp_pkg::ERASE_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire pewp_pkg::pewp_cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [pewp_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_timeout,
    input wire logic [pewp_pkg::DATA_W-1:0] byte_lines_i,
    output pewp_pkg::pewp_pins_t pins_o
);

    // Wide enough for the longest wait at its default
    localparam int unsigned CNT_W = 24;

    pewp_pkg::pewp_state_t state_r; // Sequencer state
    logic [CNT_W-1:0] cnt_r; // Phase timer within a state
    logic [CNT_W-1:0] busy_r; // Elapsed time since the write strobe ended
    logic polling_r; // Current read is a completion poll
    logic [pewp_pkg::DATA_W-1:0] wdata_r; // Byte being written, kept for polling
    logic [pewp_pkg::DATA_W-1:0] sync1_r; // First synchroniser stage
    logic [pewp_pkg::DATA_W-1:0] sync2_r; // Second stage, the only one logic reads
    logic poll_match; // Bit 7 came back true
    logic poll_expired; // Internal write overran its longest time

    // Counter limit compare, cast to the counter width
    function automatic logic reached(input logic [CNT_W-1:0] c, input int unsigned lim);
        reached = (c >= CNT_W'(lim - 1));
    endfunction : reached

    // The byte lines arrive asynchronously; two flops before any use
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= pewp_pkg::DATA_RESET;
            sync2_r <= pewp_pkg::DATA_RESET;
        end
        else
        begin
            sync1_r <= byte_lines_i;
            sync2_r <= sync1_r;
        end
    end

    // Completion: true bit 7 means the internal cycle ended
    assign poll_match = (sync2_r[pewp_pkg::POLL_BIT] == wdata_r[pewp_pkg::POLL_BIT]); // (R12) (R13) (R14)
    assign poll_expired = reached(busy_r, PROGRAM_CYCLES); // (R11)

    // Main sequencer and pin drive; all pins are flops
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= pewp_pkg::PEWP_IDLE;
            cnt_r <= '0;
            polling_r <= 1'h0;
            wdata_r <= pewp_pkg::DATA_RESET;
            cmd_ready <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_data <= pewp_pkg::DATA_RESET;
            rsp_timeout <= 1'h0;
            // Strobes idle high from reset so no false write edge appears
            pins_o.addr <= pewp_pkg::ADDR_RESET;
            pins_o.chip_en_n <= pewp_pkg::PIN_HIGH; // (R15)
            pins_o.out_en_n <= pewp_pkg::PIN_HIGH;
            pins_o.write_en_n <= pewp_pkg::PIN_HIGH;
            pins_o.out_en_elevated <= pewp_pkg::PIN_LOW;
            pins_o.byte_lines_o <= pewp_pkg::DATA_RESET;
            pins_o.byte_lines_oe <= 1'h0;
        end
        else
        begin
            rsp_valid <= 1'h0;
            cnt_r <= cnt_r + CNT_W'(1);
            case (state_r)
                pewp_pkg::PEWP_IDLE:
                begin
                    cnt_r <= '0;
                    cmd_ready <= 1'h1;
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'h0;
                        rsp_timeout <= 1'h0;
                        polling_r <= 1'h0;
                        // Address goes out one cycle before chip enable
                        pins_o.addr <= cmd.addr[pewp_pkg::ADDR_W-1:0]; // (R1) (R2)
                        wdata_r <= cmd.data;
                        if (cmd.op == pewp_pkg::PEWP_OP_WRITE)
                        begin
                            // Drive data while OE still high: bus turned round
                            pins_o.byte_lines_o <= cmd.data;
                            pins_o.byte_lines_oe <= 1'h1;
                            state_r <= pewp_pkg::PEWP_WR_SETUP;
                        end
                        else if (cmd.op == pewp_pkg::PEWP_OP_ERASE)
                        begin
                            // CE and WE stay high, only OE is raised
                            pins_o.out_en_elevated <= 1'h1; // (R17)
                            state_r <= pewp_pkg::PEWP_ERASE;
                        end
                        else
                        begin
                            state_r <= pewp_pkg::PEWP_RD_ADDR;
                        end
                    end
                end
                pewp_pkg::PEWP_RD_ADDR:
                begin
                    // Select after the address has settled; WE untouched
                    pins_o.chip_en_n <= pewp_pkg::PIN_LOW; // (R2) (R3)
                    pins_o.out_en_n <= pewp_pkg::PIN_LOW; // (R4)
                    cnt_r <= '0;
                    state_r <= pewp_pkg::PEWP_RD_OE;
                end
                pewp_pkg::PEWP_RD_OE:
                begin
                    // Transparent read: wait access plus synchroniser delay
                    if (reached(cnt_r, pewp_pkg::READ_WAIT_CYC)) // (R5)
                    begin
                        state_r <= pewp_pkg::PEWP_RD_CAP;
                    end
                end
                pewp_pkg::PEWP_RD_CAP:
                begin
                    pins_o.chip_en_n <= pewp_pkg::PIN_HIGH;
                    pins_o.out_en_n <= pewp_pkg::PIN_HIGH;
                    cnt_r <= '0;
                    state_r <= pewp_pkg::PEWP_RD_GAP;
                    if (!polling_r)
                    begin
                        rsp_valid <= 1'h1;
                        rsp_data <= sync2_r;
                    end
                    else if (poll_match || poll_expired) // (R14)
                    begin
                        // A true bit 7 ends the poll; overrun reports timeout
                        polling_r <= 1'h0;
                        rsp_valid <= 1'h1;
                        rsp_data <= sync2_r;
                        rsp_timeout <= !poll_match;
                    end
                end
                pewp_pkg::PEWP_RD_GAP:
                begin
                    // Let the memory float the lines before anything else drives
                    if (reached(cnt_r, pewp_pkg::FLOAT_CYC))
                    begin
                        state_r <= polling_r ? pewp_pkg::PEWP_RD_ADDR : pewp_pkg::PEWP_IDLE;
                    end
                end
                pewp_pkg::PEWP_WR_SETUP:
                begin
                    // CE and WE fall in the same cycle with OE high; the address latches once both are low
                    pins_o.chip_en_n <= pewp_pkg::PIN_LOW; // (R6) (R7)
                    pins_o.write_en_n <= pewp_pkg::PIN_LOW; // (R6) (R16)
                    cnt_r <= '0;
                    state_r <= pewp_pkg::PEWP_WR_PULSE;
                end
                pewp_pkg::PEWP_WR_PULSE:
                begin
                    // Pulse kept above the noise filter and the minimum width
                    if (reached(cnt_r, pewp_pkg::STORE_PULSE_CYC) &&
                        reached(cnt_r, pewp_pkg::NOISE_PULSE_CYC + 1)) // (R9) (R18)
                    begin
                        // WE rises first, so it is the edge that latches data
                        pins_o.write_en_n <= pewp_pkg::PIN_HIGH; // (R8)
                        state_r <= pewp_pkg::PEWP_WR_HOLD;
                    end
                end
                pewp_pkg::PEWP_WR_HOLD:
                begin
                    // Data and CE held one more cycle past the rising WE
                    pins_o.chip_en_n <= pewp_pkg::PIN_HIGH;
                    pins_o.byte_lines_oe <= 1'h0;
                    cnt_r <= '0;
                    // No new strobe until polling sees completion or the poll budget runs out
                    polling_r <= 1'h1; // (R10) (R19)
                    state_r <= pewp_pkg::PEWP_RD_GAP;
                end
                pewp_pkg::PEWP_ERASE:
                begin
                    if (reached(cnt_r, ERASE_CYCLES)) // (R17)
                    begin
                        pins_o.out_en_elevated <= 1'h0;
                        rsp_valid <= 1'h1;
                        rsp_data <= pewp_pkg::DATA_RESET;
                        state_r <= pewp_pkg::PEWP_RD_GAP;
                    end
                end
                default:
                begin
                    state_r <= pewp_pkg::PEWP_IDLE;
                end
            endcase
        end
    end

    // Time since the strobe ended, bounding the poll; saturates to avoid wrap
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busy_r <= '0;
        end
        else if (state_r == pewp_pkg::PEWP_WR_HOLD)
        begin
            busy_r <= '0;
        end
        else if (polling_r && !poll_expired)
        begin
            busy_r <= busy_r + CNT_W'(1); // (R11)
        end
    end

endmodule : pewp_host

`default_nettype wire

/* hdl/pewp_pkg.sv */
/*
 * Constants, states and carriers for the parallel byte-wide EEPROM host.
 * Assumes a 100 MHz clock; every pin count below is derived from that rate.
 */
`default_nettype none

package pewp_pkg;

    // Array geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned POLL_BIT = 7;

    // Clock and pin timing, in their own units
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned READ_ACCESS_NS = 55;
    localparam int unsigned STORE_PULSE_MIN_NS = 30;
    localparam int unsigned NOISE_PULSE_NS = 20;
    localparam int unsigned FLOAT_NS = 30;
    localparam int unsigned INTERNAL_PROGRAM_TIME_MS = 5;
    localparam int unsigned CHIP_ERASE_TIME_MS = 50;
    localparam int unsigned SYNC_STAGES = 2;

    // Least times round up to whole cycles
    localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_PULSE_CYC =
        (STORE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NOISE_PULSE_CYC = (NOISE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sample the bus only after access time plus the synchroniser delay
    localparam int unsigned READ_WAIT_CYC = READ_ACCESS_CYC + SYNC_STAGES;
    // Longest times round down
    localparam int unsigned PROGRAM_CYC = (INTERNAL_PROGRAM_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYC = (CHIP_ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // Idle levels of the pins
    localparam logic PIN_HIGH = 1'h1;
    localparam logic PIN_LOW = 1'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // Commands from the user side
    typedef enum logic [1:0]
    {
        PEWP_OP_READ = 2'h0,
        PEWP_OP_WRITE = 2'h1,
        PEWP_OP_ERASE = 2'h2
    } pewp_op_t;

    // Sequencer states, Gray along read and write paths up to PEWP_RD_GAP
    typedef enum logic [3:0]
    {
        PEWP_IDLE = 4'h0,
        PEWP_RD_ADDR = 4'h1,
        PEWP_RD_OE = 4'h3,
        PEWP_RD_CAP = 4'h2,
        PEWP_RD_GAP = 4'h6,
        PEWP_WR_SETUP = 4'h4,
        PEWP_WR_PULSE = 4'h5,
        PEWP_WR_HOLD = 4'h7,
        PEWP_ERASE = 4'hc
    } pewp_state_t;

    // User request
    typedef struct packed
    {
        pewp_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } pewp_cmd_t;

    // Pins driven toward the memory
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic chip_en_n;
        logic out_en_n;
        logic write_en_n;
        logic out_en_elevated;
        logic [DATA_W-1:0] byte_lines_o;
        logic byte_lines_oe;
    } pewp_pins_t;

endpackage : pewp_pkg

`default_nettype wire

/* verif/pewp_host_assertions.sv */
/* Pin and user-port checks for the EEPROM host.
   Sees only the ports of pewp_host; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module pewp_host_assertions
#(
    parameter int unsigned PROGRAM_CYCLES = 200,
    parameter int unsigned ERASE_CYCLES = 50
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire pewp_pkg::pewp_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [pewp_pkg::DATA_W-1:0] rsp_data,
    input wire logic rsp_timeout,
    input wire logic [pewp_pkg::DATA_W-1:0] byte_lines_i,
    input wire pewp_pkg::pewp_pins_t pins_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // A request is taken on this cycle
    wire take = cmd_valid && cmd_ready;
    // Cycles the erase level has stood, and cycles since write enable was last low
    int unsigned elev_cnt;
    int unsigned since_we;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            elev_cnt <= '0;
            since_we <= '0;
        end
        else
        begin
            elev_cnt <= pins_o.out_en_elevated ? elev_cnt + 32'h1 : '0;
            since_we <= !pins_o.write_en_n ? '0 : since_we + 32'h1;
        end
    end
    AST_ERASE_WIDTH: assert property ($fell(pins_o.out_en_elevated) |->
        elev_cnt == ERASE_CYCLES) else $error("erase level width wrong");
    AST_TMO_LATE: assert property ($rose(rsp_timeout) |->
        since_we >= PROGRAM_CYCLES) else $error("timeout before poll budget");
    AST_WE_SELECTED: assert property (!pins_o.write_en_n |-> !pins_o.chip_en_n && pins_o.out_en_n)
        else $error("strobe without select");
    AST_WE_FOLLOWS_TAKE: assert property (take && cmd.op == pewp_pkg::PEWP_OP_WRITE |->
        ##[1:3] !pins_o.write_en_n) else $error("write strobe late");
    AST_NO_FIGHT: assert property (!pins_o.out_en_n |-> !pins_o.byte_lines_oe)
        else $error("bus fight");
    AST_RD_WE_HIGH: assert property (!pins_o.out_en_n |-> pins_o.write_en_n)
        else $error("read with strobe low");
    AST_ADDR_HELD: assert property (!pins_o.chip_en_n && !$past(pins_o.chip_en_n)
        |-> $stable(pins_o.addr)) else $error("address moved while selected");
    AST_PULSE_MIN: assert property ($fell(pins_o.write_en_n) |-> !pins_o.write_en_n [*3])
        else $error("strobe too short");
    AST_DATA_HELD: assert property (!pins_o.write_en_n |->
        pins_o.byte_lines_oe && $stable(pins_o.byte_lines_o)) else $error("data not held");
    AST_READ_TIME: assert property (take && cmd.op == pewp_pkg::PEWP_OP_READ |->
        ##[10:12] rsp_valid) else $error("read answer late");
    AST_ERASE_LEVELS: assert property (pins_o.out_en_elevated |->
        pins_o.chip_en_n && pins_o.write_en_n) else $error("erase with strobes low");
    // Main traffic kinds
    cover property (take && cmd.op == pewp_pkg::PEWP_OP_READ);
    cover property (take && cmd.op == pewp_pkg::PEWP_OP_WRITE);
    cover property (take && cmd.op == pewp_pkg::PEWP_OP_ERASE);
    cover property ($rose(rsp_timeout));
endmodule : pewp_host_assertions
bind pewp_host pewp_host_assertions #(.PROGRAM_CYCLES(PROGRAM_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) i_chk (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .byte_lines_i(byte_lines_i), .pins_o(pins_o));
`default_nettype wire

/* verif/pewp_mem_model.sv */
/* Behavioural byte-wide EEPROM for the host bench.
   Assumes the bench resolves the shared byte lines. */
`timescale 1ns/1ps
`default_nettype none
module pewp_mem_model
(
    input wire logic clk,
    input wire pewp_pkg::pewp_pins_t pins,
    input wire logic [7:0] byte_lines,
    input wire logic [15:0] prog_cyc,
    output logic [7:0] mem_o,
    output logic mem_oe
);
    logic [7:0] mem [0:4095];
    logic [11:0] wa; // Latched address
    logic [7:0] wd; // Latched data
    logic open = 1'h0; // Strobe seen, data not yet latched
    logic busy = 1'h0; // Internal write running
    logic [15:0] left; // Timer cycles still to run
    realtime t0; // When the later falling strobe came
    initial
    begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
    end
    // Busy reads ignore the address and show the complement
    assign mem_oe = !pins.chip_en_n && !pins.out_en_n && pins.write_en_n;
    assign mem_o = busy ? ~wd : mem[pins.addr];
    // Later falling strobe latches address; a busy part ignores it
    always @(negedge pins.write_en_n or negedge pins.chip_en_n)
        if (!pins.write_en_n && !pins.chip_en_n && pins.out_en_n && !busy)
        begin
            wa = pins.addr;
            open = 1'h1;
            t0 = $realtime;
        end
    // Earlier rising strobe latches data; glitches are dropped
    always @(posedge pins.write_en_n or posedge pins.chip_en_n)
        if (open)
        begin
            open = 1'h0;
            wd = byte_lines;
            if ($realtime - t0 >= 20.0)
            begin
                busy = 1'h1;
                left = prog_cyc;
            end
        end
    // On-chip timer; the byte is cleared and written in one commit
    always @(posedge clk)
        if (busy && left == 16'h0000)
        begin
            mem[wa] <= wd;
            busy <= 1'h0;
        end
        else if (busy)
            left <= left - 16'h0001;
    // Elevated output enable with both strobes high clears all
    always @(negedge pins.out_en_elevated)
        if (pins.chip_en_n && pins.write_en_n)
            for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
endmodule : pewp_mem_model
`default_nettype wire

/* verif/test_pewp_host.sv */
/* Self-checking bench for the EEPROM host sequencer.
   Assumes pewp_mem_model stands on the far side of the pins. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_pewp_host;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic cmd_valid = 1'h0;
    pewp_pkg::pewp_cmd_t cmd = '0;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_timeout;
    wire [7:0] byte_lines;
    pewp_pkg::pewp_pins_t pins;
    logic [7:0] mem_o;
    logic mem_oe;
    logic [15:0] prog_cyc = 16'h0010; // Write time of the part
    logic [7:0] last_r = 8'h00; // Last resolved bus level
    logic [7:0] exp_mem [0:4095]; // Expected contents
    logic [11:0] ra; // Random address
    int n_fail = 0;
    int check_count = 0;
    int seed_v;
    initial
    begin
        forever #5 clk = ~clk;
    end
    // No pull on the lines, so a float must not look like old data
    assign byte_lines = pins.byte_lines_oe ? pins.byte_lines_o : mem_oe ? mem_o : ~last_r;
    // Reset gives the floating lines a known level instead of a lasting unknown
    always @(posedge clk) last_r <= reset ? 8'h00 : byte_lines;
    pewp_host #(.PROGRAM_CYCLES(200), .ERASE_CYCLES(50)) i_dut (.clk(clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .byte_lines_i(byte_lines), .pins_o(pins));
    pewp_mem_model i_mem (.clk(clk), .pins(pins), .byte_lines(byte_lines), .prog_cyc(prog_cyc),
        .mem_o(mem_o), .mem_oe(mem_oe));
    function automatic logic [7:0] exp_rd(input logic [11:0] a);
        return exp_mem[a];
    endfunction : exp_rd
    // One request, then wait for its answer
    task automatic run(input pewp_pkg::pewp_op_t o, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd_valid <= 1'h1;
        cmd <= {o, a, d};
        do @(posedge clk); while (cmd_ready !== 1'h1);
        cmd_valid <= 1'h0;
        while (rsp_valid !== 1'h1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000)
            n_fail++;
    endtask : run
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        prog_cyc <= 16'($urandom_range(120, 0));
        run(pewp_pkg::PEWP_OP_WRITE, a, d);
        exp_mem[a] = d;
        `CHK("poll_data", d, rsp_data)
        `CHK("poll_tmo", 1'h0, rsp_timeout)
    endtask : wr
    task automatic rd(input logic [11:0] a);
        run(pewp_pkg::PEWP_OP_READ, a, 8'h00);
        `CHK("rd_data", exp_rd(a), rsp_data)
    endtask : rd
    task end_of_test;
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        seed_v = $urandom(37);
        for (int i = 0; i < 4096; i++) exp_mem[i] = 8'hff;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        rd(12'h000);
        // Same byte twice shows the clear before programming
        wr(12'h000, 8'h0f);
        wr(12'h000, 8'hf0);
        wr(12'hfff, 8'h80);
        wr(12'h7ff, 8'h7f);
        rd(12'h000);
        rd(12'hfff);
        for (int i = 0; i < 8; i++)
        begin
            ra = 12'($urandom_range(4095, 0));
            wr(ra, 8'($urandom));
            rd(ra);
            rd(12'($urandom));
        end
        run(pewp_pkg::PEWP_OP_ERASE, 12'h000, 8'h00);
        `CHK("erase_rsp", 8'h00, rsp_data)
        for (int i = 0; i < 4096; i++) exp_mem[i] = 8'hff;
        rd(12'hfff);
        // A slow part outlasts the host's poll budget
        prog_cyc <= 16'h0190;
        run(pewp_pkg::PEWP_OP_WRITE, 12'h123, 8'h5a);
        `CHK("timeout", 1'h1, rsp_timeout)
        repeat (500) @(posedge clk);
        exp_mem[12'h123] = 8'h5a;
        rd(12'h123);
        end_of_test();
    end
    // Cuts a hang short
    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule : test_pewp_host
`default_nettype wire
